// *** hdl/wmad_pkg.sv ***
// constants and types for the word move and add/sub opcode decoder
`default_nettype none

package wmad_pkg;

  localparam int unsigned BUF_DEPTH = 5;

  localparam logic [7:0] OP_PREFIX      = 8'h01;
  localparam logic [7:0] OP_PTR         = 8'h05;
  localparam logic [7:0] OP_SADDRP_IMM  = 8'h0c;
  localparam logic [7:0] OP_SFRP_IMM    = 8'h0b;
  localparam logic [7:0] OP_RP_RP       = 8'h24;
  localparam logic [7:0] OP_AX_SADDRP   = 8'h1c;
  localparam logic [7:0] OP_SADDRP_AX   = 8'h1a;
  localparam logic [7:0] OP_AX_SFRP     = 8'h11;
  localparam logic [7:0] OP_SFRP_AX     = 8'h13;
  localparam logic [7:0] RP_IMM_MASK    = 8'hf9;
  localparam logic [7:0] RP_IMM_VAL     = 8'h60;
  localparam logic [7:0] PTR_MASK       = 8'hfe;
  localparam logic [7:0] PTR_LOAD_VAL   = 8'he2;
  localparam logic [7:0] PTR_STORE_VAL  = 8'he6;
  localparam logic [7:0] RP_SEL_MASK    = 8'h99;
  localparam logic [7:0] RP_SEL_VAL     = 8'h08;

  localparam logic [7:0] ARITH_MASK     = 8'hfc;
  localparam logic [7:0] AR_A_IMM       = 8'ha8;
  localparam logic [7:0] AR_SD_IMM      = 8'h68;
  localparam logic [7:0] AR_R_R         = 8'h88;
  localparam logic [7:0] AR_A_SD        = 8'h98;
  localparam logic [7:0] AR_SD_SD       = 8'h78;
  localparam logic [7:0] R_SEL_MASK     = 8'h88;
  localparam logic [7:0] R_SEL_VAL      = 8'h00;
  localparam logic [7:0] PAIR_POINTER_MASK      = 8'he0;
  localparam logic [7:0] PAIR_POINTER_VAL       = 8'h00;
  localparam logic [7:0] MEM2_MASK      = 8'h8c;
  localparam logic [7:0] MEM2_VAL       = 8'h08;

  // field positions
  localparam int unsigned FORM_OFS_BIT  = 4;
  localparam int unsigned PAIR_LSB      = 1;
  localparam int unsigned PAIR2_LSB     = 5;
  localparam int unsigned REG1_LSB      = 4;
  localparam int unsigned MODE_LSB      = 4;

  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;
  localparam logic [2:0] LEN_5 = 3'h5;

  typedef enum logic [1:0] {
    CLS_NONE,
    CLS_WORD_MOVE,
    CLS_ARITH,
    CLS_UNSUPPORTED
  } wmad_class_e;

  typedef enum logic [4:0] {
    F_NONE,
    F_RP_IMM,
    F_SADDRP_IMM,
    F_SFRP_IMM,
    F_RP_RP,
    F_AX_SADDRP,
    F_SADDRP_AX,
    F_AX_SFRP,
    F_SFRP_AX,
    F_AX_PTR,
    F_PTR_AX,
    F_A_IMM,
    F_SADDR_IMM,
    F_SFR_IMM,
    F_R_R,
    F_A_SADDR,
    F_A_SFR,
    F_SADDR_SADDR,
    F_A_MEM
  } wmad_form_e;

endpackage

`default_nettype wire

// *** hdl/wmad_byte_buf.sv ***
// holding buffer for the bytes of the instruction being gathered
`default_nettype none

module wmad_byte_buf (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            wr_i,
  input  wire logic [2:0]      idx_i,
  input  wire logic [7:0]      data_i,
  output var  logic [4:0][7:0] bytes_o
);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bytes_o <= '0;
    end
    else if (wr_i && (idx_i < 3'(wmad_pkg::BUF_DEPTH)))
    begin
      bytes_o[idx_i] <= data_i;
    end
  end

endmodule

`default_nettype wire

// *** hdl/wmad_decoder.sv ***
// opcode decoder for word moves and 8-bit add/sub instruction forms
`default_nettype none

module wmad_decoder (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 byte_valid_i,
  input  wire logic [7:0]           byte_i,
  output var  logic                 dec_valid_o,
  output var  wmad_pkg::wmad_class_e dec_class_o,
  output var  wmad_pkg::wmad_form_e dec_form_o,
  output var  logic [1:0]           arith_op_o,
  output var  logic                 ext_space_o,
  output var  logic                 dest_mem_o,
  output var  logic [2:0]           sel_a_o,
  output var  logic [2:0]           sel_b_o,
  output var  logic                 ptr_pick_o,
  output var  logic [4:0]           form_field_o,
  output var  logic [2:0]           mem_mode_o,
  output var  logic [7:0]           offset_a_o,
  output var  logic [7:0]           offset_b_o,
  output var  logic [15:0]          imm_o,
  output var  logic [15:0]          mem_offset_o,
  output var  logic [2:0]           length_o
);

  logic [2:0]      cnt;
  logic [4:0][7:0] buf_q;
  logic [4:0][7:0] v;
  logic [2:0]      need;
  logic            complete;

  function automatic logic hit(input logic [7:0] b,
                               input logic [7:0] m,
                               input logic [7:0] val);
    hit = ((b & m) == val);
  endfunction

  // total instruction length from the first two bytes
  function automatic logic [2:0] len_f(input logic [7:0] b0,
                                       input logic [7:0] b1);
    logic [2:0] n;
    n = wmad_pkg::LEN_1;
    if (b0 == wmad_pkg::OP_PREFIX)
    begin
      // prefix never completes at one byte, so b1 may still be stale
      if (b1 == wmad_pkg::OP_PTR)
        n = wmad_pkg::LEN_3;
      else if (hit(b1, wmad_pkg::ARITH_MASK, wmad_pkg::AR_SD_IMM))
        n = wmad_pkg::LEN_4;
      else if (hit(b1, wmad_pkg::ARITH_MASK, wmad_pkg::AR_A_SD))
        n = wmad_pkg::LEN_3;
      else if (hit(b1, wmad_pkg::PAIR_POINTER_MASK, wmad_pkg::PAIR_POINTER_VAL))
        n = wmad_pkg::LEN_5;
      else
        n = wmad_pkg::LEN_2;
    end
    else if (b0 == wmad_pkg::OP_SADDRP_IMM || b0 == wmad_pkg::OP_SFRP_IMM)
      n = wmad_pkg::LEN_4;
    else if (b0 == wmad_pkg::OP_RP_RP || b0 == wmad_pkg::OP_PTR)
      n = wmad_pkg::LEN_2;
    else if (b0 == wmad_pkg::OP_AX_SADDRP || b0 == wmad_pkg::OP_SADDRP_AX
             || b0 == wmad_pkg::OP_AX_SFRP || b0 == wmad_pkg::OP_SFRP_AX)
      n = wmad_pkg::LEN_2;
    else if (hit(b0, wmad_pkg::RP_IMM_MASK, wmad_pkg::RP_IMM_VAL))
      n = wmad_pkg::LEN_3;
    else if (hit(b0, wmad_pkg::ARITH_MASK, wmad_pkg::AR_A_IMM))
      n = wmad_pkg::LEN_2;
    else if (hit(b0, wmad_pkg::ARITH_MASK, wmad_pkg::AR_SD_IMM))
      n = wmad_pkg::LEN_3;
    else if (hit(b0, wmad_pkg::ARITH_MASK, wmad_pkg::AR_R_R))
      n = wmad_pkg::LEN_2;
    else if (hit(b0, wmad_pkg::ARITH_MASK, wmad_pkg::AR_A_SD))
      n = wmad_pkg::LEN_2;
    else if (hit(b0, wmad_pkg::ARITH_MASK, wmad_pkg::AR_SD_SD))
      n = wmad_pkg::LEN_3;
    else if (hit(b0, wmad_pkg::PAIR_POINTER_MASK, wmad_pkg::PAIR_POINTER_VAL)
             && b0 != 8'h00)
      n = b0[wmad_pkg::FORM_OFS_BIT] ? wmad_pkg::LEN_4
                                     : wmad_pkg::LEN_2;
    len_f = n;
  endfunction

  wmad_byte_buf u_buf (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_i    (byte_valid_i),
    .idx_i   (cnt),
    .data_i  (byte_i),
    .bytes_o (buf_q)
  );

  always_comb
  begin
    v = buf_q;
    if (cnt < 3'(wmad_pkg::BUF_DEPTH))
      v[cnt] = byte_i;
    need = len_f(v[0], v[1]);
    complete = byte_valid_i && ((cnt + 3'h1) >= need);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt <= 3'h0;
    else if (complete)
      cnt <= 3'h0;
    else if (byte_valid_i)
      cnt <= cnt + 3'h1;
  end

  wmad_pkg::wmad_class_e next_class;
  wmad_pkg::wmad_form_e  next_form;
  logic [1:0]            next_op;
  logic                  next_ext;
  logic                  next_dmem;
  logic [2:0]            next_sel_a;
  logic [2:0]            next_sel_b;
  logic                  next_ptr;
  logic [4:0]            next_ff;
  logic [2:0]            next_mm;
  logic [7:0]            next_off_a;
  logic [7:0]            next_off_b;
  logic [15:0]           next_imm;
  logic [15:0]           next_moff;

  always_comb
  begin
    next_class = wmad_pkg::CLS_UNSUPPORTED;
    next_form  = wmad_pkg::F_NONE;
    next_op    = 2'h0;
    next_ext   = (v[0] == wmad_pkg::OP_PREFIX);
    next_dmem  = 1'b0;
    next_sel_a = 3'h0;
    next_sel_b = 3'h0;
    next_ptr   = 1'b0;
    next_ff    = 5'h0;
    next_mm    = 3'h0;
    next_off_a = 8'h00;
    next_off_b = 8'h00;
    next_imm   = 16'h0000;
    next_moff  = 16'h0000;
    if (next_ext)
    begin
      next_op = v[1][1:0];
      if (v[1] == wmad_pkg::OP_PTR)
      begin
        next_ptr = v[2][0];
        if (hit(v[2], wmad_pkg::PTR_MASK, wmad_pkg::PTR_LOAD_VAL))
        begin
          next_class = wmad_pkg::CLS_WORD_MOVE;
          next_form  = wmad_pkg::F_AX_PTR;
        end
        else if (hit(v[2], wmad_pkg::PTR_MASK, wmad_pkg::PTR_STORE_VAL))
        begin
          next_class = wmad_pkg::CLS_WORD_MOVE;
          next_form  = wmad_pkg::F_PTR_AX;
        end
      end
      else if (hit(v[1], wmad_pkg::ARITH_MASK, wmad_pkg::AR_SD_IMM))
      begin
        next_class = wmad_pkg::CLS_ARITH;
        next_form  = wmad_pkg::F_SFR_IMM;
        next_dmem  = 1'b1;
        next_off_a = v[2];
        next_imm   = {8'h00, v[3]};
      end
      else if (hit(v[1], wmad_pkg::ARITH_MASK, wmad_pkg::AR_A_SD))
      begin
        next_class = wmad_pkg::CLS_ARITH;
        next_form  = wmad_pkg::F_A_SFR;
        next_off_a = v[2];
      end
      else if (hit(v[1], wmad_pkg::PAIR_POINTER_MASK, wmad_pkg::PAIR_POINTER_VAL)
               && hit(v[2], wmad_pkg::MEM2_MASK, wmad_pkg::MEM2_VAL))
      begin
        next_class = wmad_pkg::CLS_ARITH;
        next_form  = wmad_pkg::F_A_MEM;
        next_op    = v[2][1:0];
        next_ff    = v[1][4:0];
        next_mm    = v[2][wmad_pkg::MODE_LSB +: 3];
        next_moff  = {v[4], v[3]};
      end
    end
    else
    begin
      next_op = v[0][1:0];
      if (v[0] == wmad_pkg::OP_SADDRP_IMM || v[0] == wmad_pkg::OP_SFRP_IMM)
      begin
        next_class = wmad_pkg::CLS_WORD_MOVE;
        next_form  = (v[0] == wmad_pkg::OP_SADDRP_IMM)
                     ? wmad_pkg::F_SADDRP_IMM : wmad_pkg::F_SFRP_IMM;
        next_off_a = v[1];
        next_imm   = {v[3], v[2]};
      end
      else if (v[0] == wmad_pkg::OP_RP_RP)
      begin
        if (hit(v[1], wmad_pkg::RP_SEL_MASK, wmad_pkg::RP_SEL_VAL))
        begin
          next_class = wmad_pkg::CLS_WORD_MOVE;
          next_form  = wmad_pkg::F_RP_RP;
          next_sel_a = {1'b0, v[1][wmad_pkg::PAIR2_LSB +: 2]};
          next_sel_b = {1'b0, v[1][wmad_pkg::PAIR_LSB +: 2]};
        end
      end
      else if (v[0] == wmad_pkg::OP_AX_SADDRP
               || v[0] == wmad_pkg::OP_SADDRP_AX
               || v[0] == wmad_pkg::OP_AX_SFRP
               || v[0] == wmad_pkg::OP_SFRP_AX)
      begin
        next_class = wmad_pkg::CLS_WORD_MOVE;
        next_off_a = v[1];
        if (v[0] == wmad_pkg::OP_AX_SADDRP)
          next_form = wmad_pkg::F_AX_SADDRP;
        else if (v[0] == wmad_pkg::OP_SADDRP_AX)
          next_form = wmad_pkg::F_SADDRP_AX;
        else if (v[0] == wmad_pkg::OP_AX_SFRP)
          next_form = wmad_pkg::F_AX_SFRP;
        else
          next_form = wmad_pkg::F_SFRP_AX;
      end
      else if (v[0] == wmad_pkg::OP_PTR)
      begin
        // other second bytes belong to groups outside this decoder
        next_ptr = v[1][0];
        if (hit(v[1], wmad_pkg::PTR_MASK, wmad_pkg::PTR_LOAD_VAL))
        begin
          next_class = wmad_pkg::CLS_WORD_MOVE;
          next_form  = wmad_pkg::F_AX_PTR;
        end
        else if (hit(v[1], wmad_pkg::PTR_MASK, wmad_pkg::PTR_STORE_VAL))
        begin
          next_class = wmad_pkg::CLS_WORD_MOVE;
          next_form  = wmad_pkg::F_PTR_AX;
        end
      end
      else if (hit(v[0], wmad_pkg::RP_IMM_MASK, wmad_pkg::RP_IMM_VAL))
      begin
        next_class = wmad_pkg::CLS_WORD_MOVE;
        next_form  = wmad_pkg::F_RP_IMM;
        next_sel_a = {1'b0, v[0][wmad_pkg::PAIR_LSB +: 2]};
        next_imm   = {v[2], v[1]};
      end
      else if (hit(v[0], wmad_pkg::ARITH_MASK, wmad_pkg::AR_A_IMM))
      begin
        next_class = wmad_pkg::CLS_ARITH;
        next_form  = wmad_pkg::F_A_IMM;
        next_imm   = {8'h00, v[1]};
      end
      else if (hit(v[0], wmad_pkg::ARITH_MASK, wmad_pkg::AR_SD_IMM))
      begin
        next_class = wmad_pkg::CLS_ARITH;
        next_form  = wmad_pkg::F_SADDR_IMM;
        next_dmem  = 1'b1;
        next_off_a = v[1];
        next_imm   = {8'h00, v[2]};
      end
      else if (hit(v[0], wmad_pkg::ARITH_MASK, wmad_pkg::AR_R_R))
      begin
        if (hit(v[1], wmad_pkg::R_SEL_MASK, wmad_pkg::R_SEL_VAL))
        begin
          next_class = wmad_pkg::CLS_ARITH;
          next_form  = wmad_pkg::F_R_R;
          next_sel_a = v[1][wmad_pkg::REG1_LSB +: 3];
          next_sel_b = v[1][2:0];
        end
      end
      else if (hit(v[0], wmad_pkg::ARITH_MASK, wmad_pkg::AR_A_SD))
      begin
        next_class = wmad_pkg::CLS_ARITH;
        next_form  = wmad_pkg::F_A_SADDR;
        next_off_a = v[1];
      end
      else if (hit(v[0], wmad_pkg::ARITH_MASK, wmad_pkg::AR_SD_SD))
      begin
        next_class = wmad_pkg::CLS_ARITH;
        next_form  = wmad_pkg::F_SADDR_SADDR;
        next_dmem  = 1'b1;
        next_off_a = v[1];
        next_off_b = v[2];
      end
      else if (hit(v[0], wmad_pkg::PAIR_POINTER_MASK, wmad_pkg::PAIR_POINTER_VAL)
               && v[0] != 8'h00
               && hit(v[1], wmad_pkg::MEM2_MASK, wmad_pkg::MEM2_VAL))
      begin
        next_class = wmad_pkg::CLS_ARITH;
        next_form  = wmad_pkg::F_A_MEM;
        next_op    = v[1][1:0];
        next_ff    = v[0][4:0];
        next_mm    = v[1][wmad_pkg::MODE_LSB +: 3];
        if (v[0][wmad_pkg::FORM_OFS_BIT])
          next_moff = {v[3], v[2]};
      end
    end
    if (next_class == wmad_pkg::CLS_UNSUPPORTED)
      next_op = 2'h0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dec_valid_o <= 1'b0;
    else
      dec_valid_o <= complete;
  end

  // fields hold until the next instruction completes
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dec_class_o  <= wmad_pkg::CLS_NONE;
      dec_form_o   <= wmad_pkg::F_NONE;
      arith_op_o   <= 2'h0;
      ext_space_o  <= 1'b0;
      dest_mem_o   <= 1'b0;
      sel_a_o      <= 3'h0;
      sel_b_o      <= 3'h0;
      ptr_pick_o   <= 1'b0;
      form_field_o <= 5'h00;
      mem_mode_o   <= 3'h0;
      offset_a_o   <= 8'h00;
      offset_b_o   <= 8'h00;
      imm_o        <= 16'h0000;
      mem_offset_o <= 16'h0000;
      length_o     <= 3'h0;
    end
    else if (complete)
    begin
      dec_class_o  <= next_class;
      dec_form_o   <= next_form;
      arith_op_o   <= next_op;
      ext_space_o  <= next_ext;
      dest_mem_o   <= next_dmem;
      sel_a_o      <= next_sel_a;
      sel_b_o      <= next_sel_b;
      ptr_pick_o   <= next_ptr;
      form_field_o <= next_ff;
      mem_mode_o   <= next_mm;
      offset_a_o   <= next_off_a;
      offset_b_o   <= next_off_b;
      imm_o        <= next_imm;
      mem_offset_o <= next_moff;
      length_o     <= need;
    end
  end

endmodule

`default_nettype wire

// *** bench/wmad_decoder_properties.sv ***
// concurrent checks on the decoder's byte stream and decoded fields
`default_nettype none

module wmad_decoder_properties (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  byte_valid_i,
  input wire logic [7:0]            byte_i,
  input wire logic                  dec_valid_o,
  input var  wmad_pkg::wmad_class_e dec_class_o,
  input var  wmad_pkg::wmad_form_e  dec_form_o,
  input wire logic                  ext_space_o,
  input wire logic                  dest_mem_o,
  input wire logic [2:0]            sel_a_o,
  input wire logic [2:0]            sel_b_o,
  input wire logic                  ptr_pick_o,
  input wire logic [7:0]            offset_a_o,
  input wire logic [7:0]            offset_b_o,
  input wire logic [15:0]           imm_o,
  input wire logic [2:0]            length_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // bytes taken since the last completion, incl. the one that ended it
  logic [2:0] taken;

  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      taken <= 3'h0;
    else if (dec_valid_o)
      taken <= {2'b00, byte_valid_i};
    else if (byte_valid_i)
      taken <= taken + 3'h1;

  property p_len_count;
    dec_valid_o |-> length_o == taken;
  endproperty
  a_len_count: assert property (p_len_count)
    else $error("length differs from bytes taken");

  property p_answer;
    dec_valid_o |-> $past(byte_valid_i);
  endproperty
  a_answer: assert property (p_answer)
    else $error("completion without a byte taken");

  property p_hold;
    !dec_valid_o |-> $stable(length_o) && $stable(dec_form_o)
      && $stable(imm_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("fields moved between completions");

  property p_a_imm;
    dec_valid_o && dec_form_o == wmad_pkg::F_A_IMM |-> length_o == 3'h2
      && dec_class_o == wmad_pkg::CLS_ARITH && imm_o == {8'h00, $past(byte_i)};
  endproperty
  a_a_imm: assert property (p_a_imm)
    else $error("accumulator immediate form wrong");

  property p_sfr_imm;
    dec_valid_o && dec_form_o == wmad_pkg::F_SFR_IMM |-> length_o == 3'h4
      && ext_space_o && dest_mem_o && imm_o[7:0] == $past(byte_i);
  endproperty
  a_sfr_imm: assert property (p_sfr_imm)
    else $error("special register immediate form wrong");

  property p_r_r;
    dec_valid_o && dec_form_o == wmad_pkg::F_R_R |-> length_o == 3'h2
      && sel_a_o == $past(byte_i[6:4]) && sel_b_o == $past(byte_i[2:0]);
  endproperty
  a_r_r: assert property (p_r_r)
    else $error("register selects wrong");

  property p_a_sfr;
    dec_valid_o && dec_form_o == wmad_pkg::F_A_SFR |-> length_o == 3'h3
      && ext_space_o && offset_a_o == $past(byte_i);
  endproperty
  a_a_sfr: assert property (p_a_sfr)
    else $error("accumulator special register form wrong");

  property p_sd_sd;
    dec_valid_o && dec_form_o == wmad_pkg::F_SADDR_SADDR |-> length_o == 3'h3
      && dest_mem_o && offset_b_o == $past(byte_i);
  endproperty
  a_sd_sd: assert property (p_sd_sd)
    else $error("direct to direct form wrong");

  property p_ptr;
    dec_valid_o && dec_form_o inside {wmad_pkg::F_AX_PTR, wmad_pkg::F_PTR_AX}
      |-> ptr_pick_o == $past(byte_i[0]) && length_o == {2'b01, ext_space_o};
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer form wrong");

  property p_word_imm;
    dec_valid_o && dec_form_o == wmad_pkg::F_SADDRP_IMM |-> length_o == 3'h4
      && imm_o[15:8] == $past(byte_i);
  endproperty
  a_word_imm: assert property (p_word_imm)
    else $error("word immediate form wrong");

  c_arith: cover property (dec_valid_o && dec_class_o == wmad_pkg::CLS_ARITH);
  c_b2b: cover property (dec_valid_o ##1 dec_valid_o);
  c_bad: cover property (dec_valid_o
    && dec_class_o == wmad_pkg::CLS_UNSUPPORTED);
endmodule

bind wmad_decoder wmad_decoder_properties u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .byte_valid_i(byte_valid_i),
  .byte_i(byte_i), .dec_valid_o(dec_valid_o), .dec_class_o(dec_class_o),
  .dec_form_o(dec_form_o), .ext_space_o(ext_space_o),
  .dest_mem_o(dest_mem_o), .sel_a_o(sel_a_o), .sel_b_o(sel_b_o),
  .ptr_pick_o(ptr_pick_o), .offset_a_o(offset_a_o),
  .offset_b_o(offset_b_o), .imm_o(imm_o), .length_o(length_o)
);

`default_nettype wire

// *** bench/wmad_fetch_model.sv ***
// program memory fetch stream handing the decoder one byte at a time
`default_nettype none

module wmad_fetch_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [6:0] gap_pct_i,
  output var  logic       byte_valid_o,
  output var  logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] q[$];

  function automatic void push(input logic [7:0] b);
    q.push_back(b);
  endfunction

  initial
  begin
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
  end

  // idle data toggles so a stale byte never passes for a fresh one
  always @(negedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      byte_valid_o <= 1'b0;
    else if (q.size() > 0 && $urandom_range(99) >= gap_pct_i)
    begin
      byte_valid_o <= 1'b1;
      byte_o <= q.pop_front();
    end
    else
    begin
      byte_valid_o <= 1'b0;
      byte_o <= ~byte_o;
    end
endmodule

`default_nettype wire

// *** bench/wmad_decoder_test.sv ***
// self-checking bench for the word move and add/sub opcode decoder
`default_nettype none

module wmad_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;

  typedef logic [7:0] wmad_bq_t[$];
  typedef struct packed {
    logic [1:0]  cls;
    logic [4:0]  form;
    logic [1:0]  op;
    logic        ext;
    logic        dest;
    logic        ptr;
    logic [2:0]  len;
    logic [5:0]  sel;
    logic [7:0]  offa;
    logic [7:0]  offb;
    logic [15:0] imm;
    logic [15:0] mofs;
    logic [4:0]  ff;
    logic [2:0]  mm;
  } wmad_exp_s;

  localparam wmad_pkg::wmad_form_e FT [25] = '{
    wmad_pkg::F_A_IMM, wmad_pkg::F_SADDR_IMM, wmad_pkg::F_SFR_IMM,
    wmad_pkg::F_R_R, wmad_pkg::F_A_SADDR, wmad_pkg::F_A_SFR,
    wmad_pkg::F_SADDR_SADDR, wmad_pkg::F_A_MEM, wmad_pkg::F_A_MEM,
    wmad_pkg::F_A_MEM, wmad_pkg::F_SADDRP_IMM, wmad_pkg::F_SFRP_IMM,
    wmad_pkg::F_AX_SADDRP, wmad_pkg::F_SADDRP_AX, wmad_pkg::F_AX_SFRP,
    wmad_pkg::F_SFRP_AX, wmad_pkg::F_AX_PTR, wmad_pkg::F_PTR_AX,
    wmad_pkg::F_AX_PTR, wmad_pkg::F_PTR_AX, wmad_pkg::F_NONE,
    wmad_pkg::F_NONE, wmad_pkg::F_NONE, wmad_pkg::F_RP_IMM,
    wmad_pkg::F_RP_RP};

  logic                  clk = 1'b0;
  logic                  rst_n;
  logic [6:0]            gap;
  logic                  byte_valid;
  logic [7:0]            byte_b;
  logic                  dec_valid;
  wmad_pkg::wmad_class_e dec_class;
  wmad_pkg::wmad_form_e  dec_form;
  logic [1:0]            arith_op;
  logic                  ext;
  logic                  dest;
  logic                  ptr;
  logic [2:0]            sel_a;
  logic [2:0]            sel_b;
  logic [2:0]            len;
  logic [7:0]            offa;
  logic [7:0]            offb;
  logic [15:0]           imm;
  logic [15:0]           mofs;
  logic [4:0]            ff;
  logic [2:0]            mm;
  int                    errors;
  int                    n_tests;
  int                    cyc;
  wmad_exp_s             exq[$];
  wmad_exp_s             em;

  wmad_fetch_model fetch (
    .clk_i(clk), .rst_n_i(rst_n), .gap_pct_i(gap),
    .byte_valid_o(byte_valid), .byte_o(byte_b));

  wmad_decoder uut (
    .clk_i(clk), .rst_n_i(rst_n), .byte_valid_i(byte_valid),
    .byte_i(byte_b), .dec_valid_o(dec_valid), .dec_class_o(dec_class),
    .dec_form_o(dec_form), .arith_op_o(arith_op), .ext_space_o(ext),
    .dest_mem_o(dest), .sel_a_o(sel_a), .sel_b_o(sel_b),
    .ptr_pick_o(ptr), .form_field_o(ff), .mem_mode_o(mm),
    .offset_a_o(offa), .offset_b_o(offb), .imm_o(imm),
    .mem_offset_o(mofs), .length_o(len));

  always #5 clk = ~clk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic ok, input string what);
    n_tests++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  function automatic wmad_bq_t bytes_of(input int k, input logic [1:0] op,
                                        input logic [7:0] a, b, c);
    logic [7:0] mf;
    logic [7:0] m2;
    mf = c[0] ? 8'h06 : 8'h0e;
    m2 = 8'h08 | (c & 8'h70) | {6'h00, op};
    case (k)
      0: return '{8'ha8 | op, a};
      1: return '{8'h68 | op, a, b};
      2: return '{8'h01, 8'h68 | op, a, b};
      3: return '{8'h88 | op, a & 8'h77};
      4: return '{8'h98 | op, a};
      5: return '{8'h01, 8'h98 | op, a};
      6: return '{8'h78 | op, a, b};
      7: return '{mf, m2};
      8: return '{mf | 8'h10, m2, a, b};
      9: return '{8'h01, mf, m2, a, b};
      10: return '{8'h0c, a, b, c};
      11: return '{8'h0b, a, b, c};
      12: return '{8'h1c, a};
      13: return '{8'h1a, a};
      14: return '{8'h11, a};
      15: return '{8'h13, a};
      16: return '{8'h05, 8'he2 | op[0]};
      17: return '{8'h05, 8'he6 | op[0]};
      18: return '{8'h01, 8'h05, 8'he2 | op[0]};
      19: return '{8'h01, 8'h05, 8'he6 | op[0]};
      20: return '{8'h00};
      21: return '{8'h01, 8'hff};
      23: return '{8'h60 | {5'h00, op, 1'b0}, a, b};
      24: return '{8'h24, 8'h08 | (a & 8'h66)};
      default: return '{8'h05, 8'h00};
    endcase
  endfunction

  task automatic build(input int k, input logic [1:0] op);
    wmad_bq_t  bq;
    wmad_exp_s e;
    int        n;
    int        i;
    bq = bytes_of(k, op, 8'($urandom), 8'($urandom), 8'($urandom));
    n = bq.size();
    e = '0;
    e.form = FT[k];
    e.len = 3'(n);
    e.ext = (bq[0] == 8'h01);
    i = int'(e.ext);
    if (e.form == wmad_pkg::F_NONE)
      e.cls = wmad_pkg::CLS_UNSUPPORTED;
    else if (e.form >= wmad_pkg::F_A_IMM)
      e.cls = wmad_pkg::CLS_ARITH;
    else
      e.cls = wmad_pkg::CLS_WORD_MOVE;
    e.op = (e.form == wmad_pkg::F_A_MEM) ? bq[i+1][1:0] : bq[i][1:0];
    if (n > i + 1)
      e.offa = bq[i+1];
    e.offb = bq[n-1];
    e.dest = e.form inside {wmad_pkg::F_SADDR_IMM, wmad_pkg::F_SFR_IMM,
                            wmad_pkg::F_SADDR_SADDR};
    e.ptr = bq[n-1][0];
    e.sel = {bq[n-1][6:4], bq[n-1][2:0]};
    if (e.form == wmad_pkg::F_RP_RP)
      e.sel = {1'b0, bq[1][6:5], 1'b0, bq[1][2:1]};
    else if (e.form == wmad_pkg::F_RP_IMM)
      e.sel = {1'b0, bq[0][2:1], 3'h0};
    e.imm = (n - i == 4 || e.form == wmad_pkg::F_RP_IMM)
            ? {bq[n-1], bq[n-2]} : {8'h00, bq[n-1]};
    e.ff = bq[i][4:0];
    if (e.form == wmad_pkg::F_A_MEM)
      e.mm = bq[i+1][6:4];
    if (n - i == 4)
      e.mofs = {bq[n-1], bq[n-2]};
    foreach (bq[j])
      fetch.push(bq[j]);
    exq.push_back(e);
  endtask

  always @(negedge clk)
    if (rst_n === 1'b1 && dec_valid === 1'b1)
    begin
      chk(exq.size() > 0, "completion with nothing pending");
      em = exq.pop_front();
      chk(dec_class === em.cls && len === em.len, "class or length");
      chk(dec_form === em.form, "form");
      chk(em.cls != 2'(wmad_pkg::CLS_ARITH) || arith_op === em.op, "op");
      chk(em.form == 5'(wmad_pkg::F_NONE) || ext === em.ext, "prefix");
      chk(em.cls != 2'(wmad_pkg::CLS_ARITH) || dest === em.dest, "dest");
      chk(em.form inside {wmad_pkg::F_A_IMM, wmad_pkg::F_R_R,
          wmad_pkg::F_A_MEM, wmad_pkg::F_RP_IMM, wmad_pkg::F_RP_RP,
          wmad_pkg::F_AX_PTR, wmad_pkg::F_PTR_AX, wmad_pkg::F_NONE}
          || offa === em.offa, "offset");
      chk(em.form != 5'(wmad_pkg::F_SADDR_SADDR) || offb === em.offb, "offb");
      chk(!(em.form inside {wmad_pkg::F_A_IMM, wmad_pkg::F_SADDR_IMM,
          wmad_pkg::F_SFR_IMM, wmad_pkg::F_SADDRP_IMM, wmad_pkg::F_SFRP_IMM,
          wmad_pkg::F_RP_IMM})
          || imm === em.imm, "immediate");
      chk(em.form != 5'(wmad_pkg::F_A_MEM) || mofs === em.mofs, "mem");
      chk(em.form != 5'(wmad_pkg::F_A_MEM)
          || {ff, mm} === {em.ff, em.mm}, "mem fields");
      chk(!(em.form inside {wmad_pkg::F_AX_PTR, wmad_pkg::F_PTR_AX})
          || ptr === em.ptr, "pointer pick");
      chk(!(em.form inside {wmad_pkg::F_R_R, wmad_pkg::F_RP_RP,
          wmad_pkg::F_RP_IMM}) || {sel_a, sel_b} === em.sel, "sel");
    end

  // hang guard, far above the thousand or so cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      $display("[FAIL] %0t run did not finish", $time);
      finish_test();
    end
  end

  task automatic drain(input string name);
    int w;
    w = 0;
    while ((fetch.q.size() > 0 || exq.size() > 0) && w < 5000)
    begin
      @(negedge clk);
      w++;
    end
    chk(exq.size() == 0, "instructions left undecoded");
    repeat (2) @(negedge clk);
    $display("test %s done", name);
  endtask

  initial
  begin
    rst_n = 1'b0;
    gap = 7'd0;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(51));
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int k = 0; k < 25; k++)
      for (int op = 0; op < 4; op++)
        build(k, 2'(op));
    drain("every form and operation back to back");
    gap = 7'd40;
    repeat (150)
      build(int'($urandom_range(24)), 2'($urandom));
    drain("random forms with fetch stalls");
    gap = 7'd0;
    build(10, 2'd0);
    wait (fetch.q.size() == 2);
    @(negedge clk);
    rst_n = 1'b0;
    fetch.q.delete();
    exq.delete();
    @(negedge clk);
    chk(dec_valid === 1'b0 && len === 3'h0, "reset did not clear");
    rst_n = 1'b1;
    build(5, 2'd3);
    drain("reset in mid-instruction");
    finish_test();
  end
endmodule

`default_nettype wire
